// [verilog/imc_master_ctrl.sv]
// Control, status and interrupt logic of the two-wire bus master, Avalon-MM slave.
// Assumes a bit engine on clk feeding events and drive wishes; pins are open drain.
`timescale 1ns/1ps

// Operation
// - Master mode runs only while control bit 0 is set.
// - Bit 1 set: contend despite another start; clear: wait for free bus.
// - Bit 2 set loops outgoing clock and data back to the inputs.
// - Bit 4 gates the receive interrupt.
// - Bit 5 gates the byte transmitted interrupt.
// - Bit 6 gates the arbitration lost interrupt.
// - Bit 7 gates the not-acknowledge interrupt.
// - Bit 8 gates the transfer complete interrupt raised at stop.
// - Status bit 10 rises on start and falls on stop.
// - Status bit 9 flags a byte pushed into a full receive FIFO.
// - Status bit 8 flags a completed transfer with the slave.
// - Status is read-only; both registers reset to zero.
// - Status bit 7 flags a not-acknowledge to a written data byte.
module imc_master_ctrl
  import imc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [31:0]  address,
  input  wire logic         read,
  input  wire logic         write,
  input  wire logic [31:0]  writedata,
  input  wire logic [3:0]   byteenable,
  output logic      [31:0]  readdata,
  output logic              waitrequest,
  input  wire logic         scl_i,
  output logic              scl_o,
  output logic              scl_oe,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe,
  input  wire imc_eng_evt_t eng_evt,
  input  wire imc_drive_t   eng_drive,
  output logic              master_enable,
  output logic              start_grant,
  output logic              loopback_en,
  output imc_line_t         line_in,
  output logic              bus_busy,
  output logic              irq
);

  typedef struct packed {
    imc_line_t              sync1;
    imc_line_t              sync2;
    logic [15:0]            ctrl;
    logic                   nackd;
    logic                   tc;
    logic                   ovf;
    logic [IMC_IRQ_W-1:0]   pend;
    logic                   own;
    logic                   ack;
    logic [31:0]            rdata;
  } imc_state_t;

  localparam imc_state_t IMC_ST_RST = '{
    sync1: '1,
    sync2: '1,
    ctrl:  IMC_CTRL_RST,
    default: '0
  };

  imc_state_t           st;
  imc_state_t           next_st;
  imc_line_t            line_seen;
  logic                 start_pulse;
  logic                 stop_pulse;
  logic                 men;
  logic                 bd;
  logic                 loop;
  logic                 acc;
  logic                 take_rd;
  logic                 take_wr;
  logic [15:0]          stat;
  logic [15:0]          wv;
  logic [IMC_IRQ_W-1:0] evt;
  logic [IMC_IRQ_W-1:0] clr;
  logic [IMC_IRQ_W-1:0] irq_en;
  logic                 ev_nackd;
  logic                 ev_ovf;
  logic                 ev_tc;

  assign men    = st.ctrl[IMC_CB_MEN];
  assign bd     = st.ctrl[IMC_CB_BD];
  assign loop   = st.ctrl[IMC_CB_ILEN];
  assign irq_en = st.ctrl[IMC_CB_CCIE:IMC_CB_RXIE];

  // Loopback is taken after the synchroniser so the detector sees one domain
  always_comb
  begin
    if (loop)
    begin
      line_seen.scl = ~(men & eng_drive.scl_low);
      line_seen.sda = ~(men & eng_drive.sda_low);
    end
    else
    begin
      line_seen = st.sync2;
    end
  end

  imc_cond_det u_det (
    .clk         (clk),
    .resetn      (resetn),
    .line        (line_seen),
    .start_pulse (start_pulse),
    .stop_pulse  (stop_pulse),
    .bus_busy    (bus_busy)
  );

  // Bus events; detector keeps running while the master is off
  assign ev_tc    = stop_pulse & st.own;
  assign ev_nackd = men & eng_evt.nack_data;
  assign ev_ovf   = men & eng_evt.rx_push & eng_evt.rx_full;
  assign evt = {ev_tc,
                men & (eng_evt.nack_addr | eng_evt.nack_data),
                men & eng_evt.arb_lost,
                men & eng_evt.tx_done,
                men & eng_evt.rx_push};

  assign stat = {5'h00, bus_busy, st.ovf, st.tc, st.nackd, 7'h00};

  // One wait cycle per access; the answer stands at the edge that drops waitrequest
  assign acc         = read | write;
  assign waitrequest = acc & ~st.ack;
  assign take_rd     = read & st.ack;
  assign take_wr     = write & st.ack;

  assign clr = {byteenable[1] & writedata[8], {4{byteenable[0]}} & writedata[7:4]};

  always_comb
  begin
    wv      = st.ctrl;
    next_st = st;
    next_st.sync1 = '{scl: scl_i, sda: sda_i};
    next_st.sync2 = st.sync1;
    next_st.ack   = acc & ~st.ack;
    if (read & ~st.ack)
    begin
      case (address)
        IMC_ADDR_CTRL:     next_st.rdata = {16'h0000, st.ctrl};
        IMC_ADDR_STAT:     next_st.rdata = {16'h0000, stat};
        IMC_ADDR_IRQ_PEND: next_st.rdata = {16'h0000, 7'h00, st.pend, 4'h0};
        default:           next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (take_wr && address == IMC_ADDR_CTRL)
    begin
      if (byteenable[0])
      begin
        wv[7:0] = writedata[7:0];
      end
      if (byteenable[1])
      begin
        wv[15:8] = writedata[15:8];
      end
      // Reserved bits are never stored, so a careless write cannot wake them
      next_st.ctrl = wv & IMC_CTRL_WMASK;
    end
    // Reading status clears its event flags; a same-cycle event still wins
    if (take_rd && address == IMC_ADDR_STAT)
    begin
      next_st.nackd = 1'b0;
      next_st.tc    = 1'b0;
      next_st.ovf   = 1'b0;
    end
    if (ev_nackd)
    begin
      next_st.nackd = 1'b1;
    end
    if (ev_tc)
    begin
      next_st.tc = 1'b1;
    end
    if (ev_ovf)
    begin
      next_st.ovf = 1'b1;
    end
    if (take_wr && address == IMC_ADDR_IRQ_CLR)
    begin
      next_st.pend = (st.pend & ~clr) | evt;
    end
    else
    begin
      next_st.pend = st.pend | evt;
    end
    // Own transfer runs from engine activity to the next stop on the bus
    if (stop_pulse)
    begin
      next_st.own = 1'b0;
    end
    else if (men & eng_evt.active)
    begin
      next_st.own = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= IMC_ST_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign readdata      = st.rdata;
  assign master_enable = men;
  assign loopback_en   = loop;
  assign line_in       = line_seen;
  assign start_grant   = men & eng_evt.start_req & (bd | ~bus_busy);
  // In loopback the pins stay released so the bus outside is not disturbed
  assign scl_oe = men & ~loop & eng_drive.scl_low;
  assign sda_oe = men & ~loop & eng_drive.sda_low;
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign irq    = |(st.pend & irq_en);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_bus_answer: assert property (acc && waitrequest |=> !waitrequest)
    else $error("Access not answered after one wait cycle");

  a_grant_enable: assert property (start_grant |-> men && eng_evt.start_req)
    else $error("Start granted while master disabled");

  a_backoff_wait: assert property (start_grant && !bd |-> !bus_busy)
    else $error("Start granted on busy bus with backoff");

  a_loop_route: assert property (loop && men && eng_drive.sda_low
    |-> !line_in.sda && !sda_oe)
    else $error("Loopback data not routed internally");

  a_ctrl_store: assert property (take_wr && address == IMC_ADDR_CTRL && byteenable == 4'hf
    |=> {16'h0000, st.ctrl} == ($past(writedata) & {16'h0000, IMC_CTRL_WMASK}))
    else $error("Control write stored wrong bits");

  a_rx_gate: assert property (eng_evt.rx_push && men && st.ctrl[IMC_CB_RXIE] && !take_wr
    |=> irq)
    else $error("Receive interrupt missing");

  a_tx_gate: assert property (eng_evt.tx_done && men && st.ctrl[IMC_CB_TXIE] && !take_wr
    |=> irq)
    else $error("Transmit interrupt missing");

  a_arb_gate: assert property (eng_evt.arb_lost && men && st.ctrl[IMC_CB_ALIE] && !take_wr
    |=> irq)
    else $error("Arbitration lost interrupt missing");

  a_nack_gate: assert property (eng_evt.nack_addr && men && st.ctrl[IMC_CB_NAIE]
    && !take_wr |=> irq)
    else $error("Not-acknowledge interrupt missing");

  a_done_gate: assert property (ev_tc && st.ctrl[IMC_CB_CCIE] && !take_wr |=> irq)
    else $error("Transfer complete interrupt missing");

  a_irq_quiet: assert property (st.pend == '0 |-> !irq)
    else $error("Interrupt without pending event");

  a_ovf_flag: assert property (ev_ovf |=> st.ovf ##1 (st.ovf || $past(take_rd)))
    else $error("Receive overflow flag lost");

  a_tc_flag: assert property (stop_pulse && st.own |=> st.tc && !st.own)
    else $error("Transfer complete flag not set at stop");

  a_stat_ro: assert property (take_wr && address == IMC_ADDR_STAT |=> $stable(st.ctrl))
    else $error("Status write altered control");

  a_nackd_flag: assert property (ev_nackd
    |=> st.nackd && st.pend[IMC_CB_NAIE-IMC_IRQ_LSB])
    else $error("Data not-acknowledge flag not set");

  a_off_release: assert property (!men |-> !scl_oe && !sda_oe && !start_grant)
    else $error("Disabled master drives the bus");

  a_tc_clear: assert property (take_rd && address == IMC_ADDR_STAT
    && !ev_tc |=> !st.tc)
    else $error("Transfer complete flag kept after status read");

  a_ovf_clear: assert property (take_rd && address == IMC_ADDR_STAT
    && !ev_ovf |=> !st.ovf)
    else $error("Overflow flag kept after status read");

  a_nackd_clear: assert property (take_rd && address == IMC_ADDR_STAT
    && !ev_nackd |=> !st.nackd)
    else $error("Data not-acknowledge flag kept after status read");

  a_own_off: assert property (!men && !st.own |=> !st.own)
    else $error("Disabled master took a transfer");

  a_evt_off: assert property (!men |-> evt[3:0] == 4'h0)
    else $error("Engine event accepted while disabled");

  a_loop_scl: assert property (loop && men && eng_drive.scl_low
    |-> !line_in.scl && !scl_oe)
    else $error("Loopback clock not routed internally");

  a_loop_free: assert property (!loop |-> line_in == st.sync2)
    else $error("Line levels not taken from pins outside loopback");

  a_rsv_zero: assert property ((st.ctrl & ~IMC_CTRL_WMASK) == 16'h0000)
    else $error("Reserved control bit stored");

  a_rx_masked: assert property (
    st.pend == '0 && evt == 5'h01 && !st.ctrl[IMC_CB_RXIE] && !take_wr |=> !irq)
    else $error("Masked receive event raised the interrupt");

  a_pend_clear: assert property (take_wr && address == IMC_ADDR_IRQ_CLR
    |=> (st.pend & $past(clr) & ~$past(evt)) == '0)
    else $error("Pending bit not cleared");

  a_grant_idle: assert property (men && eng_evt.start_req && !bus_busy
    |-> start_grant)
    else $error("Start refused on a free bus");

  a_grant_contend: assert property (men && bd && eng_evt.start_req
    |-> start_grant)
    else $error("Start refused with backoff disabled");

  a_rdata_high: assert property (readdata[31:16] == 16'h0000)
    else $error("Upper read data not zero");

  c_stat_read: cover property (take_rd && address == IMC_ADDR_STAT && readdata[IMC_SB_TC]);
  c_own_done:  cover property (stop_pulse && st.own);
  c_grant:     cover property (start_grant && bus_busy);
  c_loop_start: cover property (loop && start_pulse);
  c_nack_irq:  cover property (eng_evt.nack_addr && irq_en[3]);

endmodule : imc_master_ctrl

// [verilog/imc_pkg.sv]
// Constants, register map and carrier types of the two-wire master control block.
// Assumes a 32-bit Avalon-MM slave port and a separate bit engine on the same clock.
package imc_pkg;

  // Byte addresses on the register bus
  localparam logic [31:0] IMC_ADDR_CTRL     = 32'hffff0900;
  localparam logic [31:0] IMC_ADDR_STAT     = 32'hffff0904;
  localparam logic [31:0] IMC_ADDR_IRQ_PEND = 32'hffff0940;
  localparam logic [31:0] IMC_ADDR_IRQ_CLR  = 32'hffff0944;

  // Control field positions
  localparam int IMC_CB_MEN  = 0;
  localparam int IMC_CB_BD   = 1;
  localparam int IMC_CB_ILEN = 2;
  localparam int IMC_CB_RSV3 = 3;
  localparam int IMC_CB_RXIE = 4;
  localparam int IMC_CB_TXIE = 5;
  localparam int IMC_CB_ALIE = 6;
  localparam int IMC_CB_NAIE = 7;
  localparam int IMC_CB_CCIE = 8;

  // Status field positions
  localparam int IMC_SB_NACKD = 7;
  localparam int IMC_SB_TC    = 8;
  localparam int IMC_SB_OVF   = 9;
  localparam int IMC_SB_BUSY  = 10;

  // Interrupt group: same layout as control bits 8:4
  localparam int IMC_IRQ_LSB = 4;
  localparam int IMC_IRQ_W   = 5;

  // Writable control bits; reserved 15:9 and 3 stay zero
  localparam logic [15:0] IMC_CTRL_WMASK = 16'h01f7;
  localparam logic [15:0] IMC_CTRL_RST   = 16'h0000;
  localparam logic [15:0] IMC_STAT_RST   = 16'h0000;

  // Events and requests from the bit engine, same clock
  typedef struct packed {
    logic start_req;
    logic active;
    logic rx_push;
    logic rx_full;
    logic tx_done;
    logic arb_lost;
    logic nack_addr;
    logic nack_data;
  } imc_eng_evt_t;

  // Engine wish to pull a line low
  typedef struct packed {
    logic scl_low;
    logic sda_low;
  } imc_drive_t;

  // Level of the two bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } imc_line_t;

endpackage : imc_pkg

// [verilog/imc_cond_det.sv]
// Start and stop condition detector with bus busy tracking.
// Assumes line levels already on the clk domain (synchronised or looped back).
`timescale 1ns/1ps
module imc_cond_det
  import imc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire imc_line_t line,
  output logic           start_pulse,
  output logic           stop_pulse,
  output logic           bus_busy
);

  typedef struct packed {
    imc_line_t prev;
    logic      start;
    logic      stop;
    logic      busy;
  } imc_det_t;

  imc_det_t st;
  imc_det_t next_st;

  always_comb
  begin
    next_st       = st;
    next_st.prev  = line;
    next_st.start = st.prev.scl & line.scl & st.prev.sda & ~line.sda;
    next_st.stop  = st.prev.scl & line.scl & ~st.prev.sda & line.sda;
    if (next_st.start)
    begin
      next_st.busy = 1'b1;
    end
    else if (next_st.stop)
    begin
      next_st.busy = 1'b0;
    end
  end

  // Idle lines are high; resetting prev high avoids a false start
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '{prev: '1, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign start_pulse = st.start;
  assign stop_pulse  = st.stop;
  assign bus_busy    = st.busy;

  a_start_busy: assert property (@(posedge clk) disable iff (!resetn)
    start_pulse |-> bus_busy)
    else $error("Bus busy not set by start");

  a_stop_idle: assert property (@(posedge clk) disable iff (!resetn)
    stop_pulse |-> !bus_busy ##1 (!bus_busy || start_pulse))
    else $error("Bus busy not cleared by stop");

endmodule : imc_cond_det

// [test/imc_bus_model.sv]
// Far side of the bus: pull-ups and one other party making start and stop.
// Assumes open-drain enables from the block; frame edges 40 ns apart.
`timescale 1ns/1ps
module imc_bus_model (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic scl_dr = 1'h0;
  logic sda_dr = 1'h0;
  // Wired-AND; a released line returns to its pull-up level
  assign scl = !(scl_oe || scl_dr);
  assign sda = !(sda_oe || sda_dr);
  // Clock is held low inside a frame and stands high between frames
  task automatic frame_start();
    // Kept off the clk edges so the pin synchroniser never races the model
    #1 sda_dr = 1'h1;
    #40 scl_dr = 1'h1;
  endtask : frame_start
  task automatic frame_stop();
    #41 scl_dr = 1'h0;
    #40 sda_dr = 1'h0;
  endtask : frame_stop
endmodule : imc_bus_model

// [test/tb_top.sv]
// Self-checking bench of the two-wire master control block.
// Assumes the block alone on clk, with the far-side model on its bus lines.
`timescale 1ns/1ps
module tb_top
  import imc_pkg::*;
();
  logic         clk = 1'h0;
  logic         resetn = 1'h0;
  logic [31:0]  address = 32'h0;
  logic         read = 1'h0;
  logic         write = 1'h0;
  logic [31:0]  writedata = 32'h0;
  logic [3:0]   byteenable = 4'hf;
  logic [31:0]  readdata;
  logic         waitrequest, scl, sda, scl_oe, sda_oe, scl_o, sda_o;
  logic         master_enable, start_grant, loopback_en, bus_busy, irq;
  imc_eng_evt_t eng_evt = '0;
  imc_drive_t   eng_drive = '0;
  imc_line_t    line_in;
  logic [15:0]  q;
  logic [7:0]   evs [4] = '{8'h20, 8'h08, 8'h04, 8'h01};
  int           miscompares = 0;
  int           check_count = 0;

  always #2 clk = ~clk;

  imc_master_ctrl imc_master_ctrl_i (
    .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .eng_evt(eng_evt),
    .eng_drive(eng_drive), .master_enable(master_enable), .start_grant(start_grant),
    .loopback_en(loopback_en), .line_in(line_in), .bus_busy(bus_busy), .irq(irq)
  );

  imc_bus_model imc_bus_model_i (
    .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda)
  );

  task automatic wrap_up();
    $display("checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stall(input string nm);
    miscompares++;
    $display("wrong value %s: expected answer, seen timeout", nm);
    wrap_up();
  endtask : stall

  // Request held until waitrequest is sampled low; two idle edges let irq settle
  task automatic acc(input logic [31:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    address   <= a;
    write     <= w;
    read      <= !w;
    writedata <= {16'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 64);
    if (n >= 64)
      stall("waitrequest");
    q = readdata[15:0];
    read  <= 1'h0;
    write <= 1'h0;
    repeat (2) @(posedge clk);
  endtask : acc

  task automatic rd(input logic [31:0] a, input logic [15:0] e, input string nm);
    acc(a, 1'h0, 16'h0);
    chk(nm, e, q);
  endtask : rd

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (bus_busy !== v && n < 200);
    if (n >= 200)
      stall("bus_busy");
  endtask : wait_busy

  task automatic pulse(input logic [7:0] e);
    eng_evt <= imc_eng_evt_t'(e);
    @(posedge clk);
    eng_evt <= '0;
    @(posedge clk);
  endtask : pulse

  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    rd(IMC_ADDR_CTRL, 16'h0000, "control reset");
    rd(IMC_ADDR_STAT, 16'h0000, "status reset");
    // Software writes reserved control bits as zero only
    acc(IMC_ADDR_CTRL, 1'h1, 16'h01f7);
    rd(IMC_ADDR_CTRL, 16'h01f7, "control reserved");
    chk("master_enable", 16'h1, master_enable);
    chk("loopback_en", 16'h1, loopback_en);
    byteenable <= 4'h2;
    acc(IMC_ADDR_CTRL, 1'h1, 16'h0000);
    byteenable <= 4'hf;
    rd(IMC_ADDR_CTRL, 16'h00f7, "control lane");
    acc(IMC_ADDR_STAT, 1'h1, 16'hffff);
    rd(IMC_ADDR_STAT, 16'h0000, "status write");
    rd(32'hffff0908, 16'h0000, "unmapped");
    $display("test registers done");
    // Each event: masked, then enabled, then cleared
    for (int i = 0; i < 4; i++)
    begin
      acc(IMC_ADDR_CTRL, 1'h1, 16'h0001);
      pulse(evs[i]);
      chk("irq masked", 16'h0, irq);
      rd(IMC_ADDR_IRQ_PEND, 16'h0010 << i, "pending");
      acc(IMC_ADDR_CTRL, 1'h1, 16'h0001 | (16'h0010 << i));
      chk("irq enabled", 16'h1, irq);
      acc(IMC_ADDR_IRQ_CLR, 1'h1, 16'h0010 << i);
      chk("irq cleared", 16'h0, irq);
      pulse(evs[i]);
      chk("irq event", 16'h1, irq);
      rd(IMC_ADDR_STAT, (i == 3) ? 16'h0080 : 16'h0, "data nack");
      acc(IMC_ADDR_IRQ_CLR, 1'h1, 16'h0010 << i);
      chk("irq cleared again", 16'h0, irq);
    end
    pulse(8'h30);
    rd(IMC_ADDR_STAT, 16'h0200, "overflow");
    rd(IMC_ADDR_STAT, 16'h0000, "overflow gone");
    pulse(8'h02);
    rd(IMC_ADDR_STAT, 16'h0000, "address nack");
    acc(IMC_ADDR_IRQ_CLR, 1'h1, 16'h01f0);
    $display("test events done");
    acc(IMC_ADDR_CTRL, 1'h1, 16'h0001);
    eng_evt <= imc_eng_evt_t'(8'h80);
    repeat (2) @(posedge clk);
    chk("grant idle", 16'h1, start_grant);
    imc_bus_model_i.frame_start();
    wait_busy(1'h1);
    chk("grant backoff", 16'h0, start_grant);
    rd(IMC_ADDR_STAT, 16'h0400, "busy");
    acc(IMC_ADDR_CTRL, 1'h1, 16'h0103);
    chk("grant contend", 16'h1, start_grant);
    eng_evt <= imc_eng_evt_t'(8'h40);
    imc_bus_model_i.frame_stop();
    wait_busy(1'h0);
    eng_evt <= '0;
    repeat (2) @(posedge clk);
    chk("irq complete", 16'h1, irq);
    rd(IMC_ADDR_STAT, 16'h0100, "complete");
    acc(IMC_ADDR_IRQ_CLR, 1'h1, 16'h0100);
    chk("irq complete off", 16'h0, irq);
    $display("test bus done");
    // Disabled master still tracks the bus but grants and drives nothing
    acc(IMC_ADDR_CTRL, 1'h1, 16'h0000);
    eng_evt   <= imc_eng_evt_t'(8'hc0);
    eng_drive <= imc_drive_t'(2'h3);
    imc_bus_model_i.frame_start();
    wait_busy(1'h1);
    chk("grant off", 16'h0, start_grant);
    chk("oe off", 16'h0, {scl_oe, sda_oe});
    imc_bus_model_i.frame_stop();
    wait_busy(1'h0);
    eng_evt <= '0;
    rd(IMC_ADDR_STAT, 16'h0000, "no complete");
    $display("test disabled done");
    eng_drive <= imc_drive_t'(2'h1);
    acc(IMC_ADDR_CTRL, 1'h1, 16'h0005);
    chk("loop line", 16'h2, line_in);
    chk("loop oe", 16'h0, sda_oe);
    acc(IMC_ADDR_CTRL, 1'h1, 16'h0001);
    chk("drive oe", 16'h1, sda_oe);
    chk("pin level", 16'h0, {scl_o, sda_o});
    eng_drive <= imc_drive_t'(2'h2);
    repeat (2) @(posedge clk);
    chk("drive scl oe", 16'h2, {scl_oe, sda_oe});
    acc(IMC_ADDR_CTRL, 1'h1, 16'h0000);
    chk("release oe", 16'h0, {scl_oe, sda_oe});
    $display("test loopback done");
    wrap_up();
  end
endmodule : tb_top
